// file: include/tmw_pkg.sv
package tmw_pkg;

  // Byte addresses on the register bus
  localparam logic [7:0] TMW_ADDR_CTRL_A   = 8'h80;
  localparam logic [7:0] TMW_ADDR_CTRL_B   = 8'h84;
  localparam logic [7:0] TMW_ADDR_CMP_A    = 8'h88;
  localparam logic [7:0] TMW_ADDR_CMP_B    = 8'h8c;
  localparam logic [7:0] TMW_ADDR_CAPT     = 8'h90;
  localparam logic [7:0] TMW_ADDR_CNT      = 8'h94;
  localparam logic [7:0] TMW_ADDR_IRQ_STAT = 8'h98;
  localparam logic [7:0] TMW_ADDR_IRQ_MASK = 8'h9c;

  // Values after reset
  localparam logic [7:0]  TMW_RST_BYTE = 8'h00;
  localparam logic [15:0] TMW_RST_WORD = 16'h0000;
  localparam logic [3:0]  TMW_RST_IRQ  = 4'h0;

  // Field positions
  localparam int TMW_WMH_LSB = 3;
  localparam int TMW_WMH_MSB = 4;

  // Interrupt status and mask bit positions
  localparam int TMW_IRQ_OVF     = 0;
  localparam int TMW_IRQ_MATCH_A = 1;
  localparam int TMW_IRQ_MATCH_B = 2;
  localparam int TMW_IRQ_CAPT    = 3;

  // Fixed TOP values
  localparam logic [15:0] TMW_TOP_MAX = 16'hffff;
  localparam logic [15:0] TMW_TOP_8   = 16'h00ff;
  localparam logic [15:0] TMW_TOP_9   = 16'h01ff;
  localparam logic [15:0] TMW_TOP_10  = 16'h03ff;

  // Waveform modes that allow the channel A toggle
  localparam logic [3:0] TMW_WM_PFC_CMPA  = 4'h9;
  localparam logic [3:0] TMW_WM_PC_CMPA   = 4'hb;
  localparam logic [3:0] TMW_WM_FAST_CAPT = 4'he;
  localparam logic [3:0] TMW_WM_FAST_CMPA = 4'hf;

  // Bus responses
  localparam logic [1:0] TMW_RESP_OKAY   = 2'h0;
  localparam logic [1:0] TMW_RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    TMW_K_NORMAL, TMW_K_CTC, TMW_K_FAST, TMW_K_PC, TMW_K_PFC, TMW_K_RESV
  } tmw_kind_t;

  typedef enum logic [1:0] {TMW_SRC_FIXED, TMW_SRC_CMPA, TMW_SRC_CAPT} tmw_top_src_t;

  typedef struct packed {
    tmw_kind_t    kind;
    tmw_top_src_t src;
    logic [15:0]  fixed_top;
  } tmw_mode_t;

  typedef struct packed {
    logic [1:0] chan_a_output_mode;
    logic [1:0] chan_b_output_mode;
    logic [1:0] rsvd;
    logic [1:0] waveform_mode_low;
  } tmw_ctrl_a_t;

  // Per-channel events; match and wrap qualified by the tick, up and cmp_top not
  typedef struct packed {
    logic tick;
    logic match;
    logic wrap;
    logic up;
    logic cmp_top;
  } tmw_evt_t;

  function automatic tmw_mode_t tmw_decode(input logic [3:0] wm);
    unique case (wm)
      4'h0: return '{TMW_K_NORMAL, TMW_SRC_FIXED, TMW_TOP_MAX};
      4'h1: return '{TMW_K_PC,     TMW_SRC_FIXED, TMW_TOP_8};
      4'h2: return '{TMW_K_PC,     TMW_SRC_FIXED, TMW_TOP_9};
      4'h3: return '{TMW_K_PC,     TMW_SRC_FIXED, TMW_TOP_10};
      4'h4: return '{TMW_K_CTC,    TMW_SRC_CMPA,  TMW_TOP_MAX};
      4'h5: return '{TMW_K_FAST,   TMW_SRC_FIXED, TMW_TOP_8};
      4'h6: return '{TMW_K_FAST,   TMW_SRC_FIXED, TMW_TOP_9};
      4'h7: return '{TMW_K_FAST,   TMW_SRC_FIXED, TMW_TOP_10};
      4'h8: return '{TMW_K_PFC,    TMW_SRC_CAPT,  TMW_TOP_MAX};
      4'h9: return '{TMW_K_PFC,    TMW_SRC_CMPA,  TMW_TOP_MAX};
      4'ha: return '{TMW_K_PC,     TMW_SRC_CAPT,  TMW_TOP_MAX};
      4'hb: return '{TMW_K_PC,     TMW_SRC_CMPA,  TMW_TOP_MAX};
      4'hc: return '{TMW_K_CTC,    TMW_SRC_CAPT,  TMW_TOP_MAX};
      4'hd: return '{TMW_K_RESV,   TMW_SRC_FIXED, TMW_TOP_MAX};
      4'he: return '{TMW_K_FAST,   TMW_SRC_CAPT,  TMW_TOP_MAX};
      4'hf: return '{TMW_K_FAST,   TMW_SRC_CMPA,  TMW_TOP_MAX};
    endcase
  endfunction

endpackage

// file: verilog/tmw_cmp_buf.sv
`timescale 1ns/100ps
`default_nettype none
module tmw_cmp_buf
  import tmw_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        wr_en,
  input  wire logic [15:0] wr_data,
  input  wire logic        immediate,
  input  wire logic        reload,
  output var  logic [15:0] buf_q,
  output var  logic [15:0] act_q
);

  // Buffer takes every software write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      buf_q <= TMW_RST_WORD;
    end else if (wr_en) begin
      buf_q <= wr_data;
    end
  end

  // Active value follows writes at once or only at the reload point
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      act_q <= TMW_RST_WORD;
    end else if (wr_en && immediate) begin
      act_q <= wr_data;
    end else if (reload) begin
      act_q <= buf_q;
    end
  end

endmodule // tmw_cmp_buf
`default_nettype wire

// file: verilog/tmw_wave_chan.sv
`timescale 1ns/100ps
`default_nettype none
module tmw_wave_chan
  import tmw_pkg::*;
(
  input  wire logic      aclk,
  input  wire logic      aresetn,
  input  wire tmw_evt_t  evt,
  input  wire tmw_kind_t kind,
  input  wire logic [1:0] out_mode,
  input  wire logic      toggle_ok,
  output var  logic      wave_q,
  output var  logic      conn_q
);

  logic wave_d;

  // Output action per waveform family; nothing moves without the tick
  always_comb begin
    wave_d = wave_q;
    if (evt.tick && out_mode != 2'b00) begin // [R19]
      unique case (kind)
        TMW_K_NORMAL, TMW_K_CTC: begin
          if (evt.match) begin
            wave_d = (out_mode == 2'b01) ? ~wave_q : out_mode[0]; // [R6]
          end
        end
        TMW_K_FAST: begin
          if (out_mode == 2'b01) begin
            if (evt.match && toggle_ok) wave_d = ~wave_q; // [R7]
          end else if (evt.wrap) begin
            wave_d = ~out_mode[0]; // [R8]
          end else if (evt.match && !evt.cmp_top) begin
            wave_d = out_mode[0]; // [R9]
          end
        end
        TMW_K_PC, TMW_K_PFC: begin
          if (evt.match) begin
            if (out_mode == 2'b01) begin
              if (toggle_ok) wave_d = ~wave_q; // [R10]
            end else begin
              wave_d = evt.up ? out_mode[0] : ~out_mode[0]; // [R11]
            end
          end
        end
        default: wave_d = wave_q; // Reserved mode holds the pin level
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wave_q <= 1'b0;
    end else begin
      wave_q <= wave_d;
    end
  end

  // Any nonzero mode takes the pin from the port function
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      conn_q <= 1'b0;
    end else begin
      conn_q <= (out_mode != 2'b00);
    end
  end

endmodule // tmw_wave_chan
`default_nettype wire

// file: verilog/tmw_timer_top.sv
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// [R1] All logic on aclk; timer tick is a one-cycle enable only.
// [R2] Phase-and-frequency-correct modes reload compare values at BOTTOM.
// [R3] Nonzero channel A output mode hands its pin to the waveform.
// [R4] Nonzero channel B output mode hands its pin to the waveform.
// [R5] Software sets each waveform pin's direction to output, else driver off.
// [R6] Non-PWM: 00 off, 01 toggle, 10 clear, 11 set on match.
// [R7] Fast PWM mode 01 toggles channel A only in modes 14/15.
// [R8] Fast PWM 10 clears on match, sets at BOTTOM; 11 inverse.
// [R9] Fast PWM ignores match when compare equals TOP; BOTTOM action stays.
// [R10] Dual-slope mode 01 toggles channel A only in modes 9/11.
// [R11] Dual-slope 10 clears on up match, sets on down; 11 inverse.
// [R12] Four-bit waveform mode from two registers; mode 13 reserved.
// [R13] Phase-correct: fixed or capture/compare-A TOP, reload TOP, overflow BOTTOM.
// [R14] Fast PWM: fixed or capture/compare-A TOP, reload BOTTOM, overflow TOP.
// [R15] Normal TOP 0xFFFF, clear-on-match TOP from compare A/capture; immediate.
// [R16] Modes 8/9 TOP from capture/compare A, reload and overflow BOTTOM.
// [R17] Upper waveform-mode bits sit at bits 4:3 of second control register.
// [R18] Capture-sourced TOP disconnects capture input and disables capture events.
// [R19] Match-driven output changes and flags happen only on tick cycles.
module tmw_timer_top
  import tmw_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        timer_tick,
  input  wire logic        capture_event,
  output var  logic        capture_enabled,
  output var  logic        wave_out_a,
  output var  logic        wave_out_b,
  output var  logic        wave_a_override,
  output var  logic        wave_b_override,
  output var  logic        irq
);

  // Merge byte lanes 0 and 1 of a write into a 16-bit value
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] strb);
    logic [15:0] r;
    r = old;
    if (strb[0]) r[7:0] = d[7:0];
    if (strb[1]) r[15:8] = d[15:8];
    return r;
  endfunction

  // Bus holding registers
  logic        aw_hold_q;
  logic [7:0]  awaddr_q;
  logic        w_hold_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        wr_do;
  logic        aw_take;
  logic        w_take;
  logic        ar_take;
  logic [31:0] rd_data;
  logic        rd_hit;
  logic        wr_hit;

  // Register file
  tmw_ctrl_a_t ctrl_a_q;
  logic [1:0]  wm_high_q;
  logic [15:0] capt_q;
  logic [15:0] cnt_q;
  logic        dir_up_q;
  logic [3:0]  stat_q;
  logic [3:0]  mask_q;

  // Mode and counter status
  logic [3:0]  waveform_mode;
  tmw_mode_t   mode;
  logic [15:0] top_v;
  logic [15:0] cmp_mask;
  logic        dual;
  logic        immediate;
  logic        at_top;
  logic        at_bot;
  logic        reload;
  logic        ovf_set;
  logic        match_a;
  logic        match_b;
  logic        capt_set;
  logic        toggle_a;
  logic [15:0] cmpa_buf;
  logic [15:0] cmpa_act;
  logic [15:0] cmpb_buf;
  logic [15:0] cmpb_act;
  logic        wr_ctrl_a;
  logic        wr_ctrl_b;
  logic        wr_cmpa;
  logic        wr_cmpb;
  logic        wr_capt;
  logic        wr_cnt;
  logic        wr_stat;
  logic        wr_mask;
  logic [3:0]  stat_d;
  tmw_evt_t    evt_a;
  tmw_evt_t    evt_b;

  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take  = s_axi_wvalid && s_axi_wready;
  assign ar_take = s_axi_arvalid && s_axi_arready;
  assign wr_do   = aw_hold_q && w_hold_q && !s_axi_bvalid;

  // Write address channel: one address held until the write is done
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q     <= 1'b0;
      awaddr_q      <= 8'h00;
      s_axi_awready <= 1'b0;
    end else begin
      if (aw_take) begin
        aw_hold_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end else if (wr_do) begin
        aw_hold_q <= 1'b0;
      end
      s_axi_awready <= !(aw_take || (aw_hold_q && !wr_do));
    end
  end

  // Write data channel, taken independently of the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_hold_q     <= 1'b0;
      wdata_q      <= 32'h0000_0000;
      wstrb_q      <= 4'h0;
      s_axi_wready <= 1'b0;
    end else begin
      if (w_take) begin
        w_hold_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end else if (wr_do) begin
        w_hold_q <= 1'b0;
      end
      s_axi_wready <= !(w_take || (w_hold_q && !wr_do));
    end
  end

  // Write decode; a miss still answers, with an error
  always_comb begin
    wr_ctrl_a = wr_do && awaddr_q == TMW_ADDR_CTRL_A && wstrb_q[0];
    wr_ctrl_b = wr_do && awaddr_q == TMW_ADDR_CTRL_B && wstrb_q[0];
    wr_cmpa   = wr_do && awaddr_q == TMW_ADDR_CMP_A && (|wstrb_q[1:0]);
    wr_cmpb   = wr_do && awaddr_q == TMW_ADDR_CMP_B && (|wstrb_q[1:0]);
    wr_capt   = wr_do && awaddr_q == TMW_ADDR_CAPT && (|wstrb_q[1:0]);
    wr_cnt    = wr_do && awaddr_q == TMW_ADDR_CNT && (|wstrb_q[1:0]);
    wr_stat   = wr_do && awaddr_q == TMW_ADDR_IRQ_STAT && wstrb_q[0];
    wr_mask   = wr_do && awaddr_q == TMW_ADDR_IRQ_MASK && wstrb_q[0];
    unique case (awaddr_q)
      TMW_ADDR_CTRL_A, TMW_ADDR_CTRL_B, TMW_ADDR_CMP_A, TMW_ADDR_CMP_B,
      TMW_ADDR_CAPT, TMW_ADDR_CNT, TMW_ADDR_IRQ_STAT, TMW_ADDR_IRQ_MASK: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // Write response follows the write by one cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= TMW_RESP_OKAY;
    end else if (wr_do) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? TMW_RESP_OKAY : TMW_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read mux; reserved bits and unused upper bits read zero
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_hit  = 1'b1;
    unique case (s_axi_araddr)
      TMW_ADDR_CTRL_A:   rd_data[7:0] = ctrl_a_q;
      TMW_ADDR_CTRL_B:   rd_data[TMW_WMH_MSB:TMW_WMH_LSB] = wm_high_q;
      TMW_ADDR_CMP_A:    rd_data[15:0] = cmpa_buf;
      TMW_ADDR_CMP_B:    rd_data[15:0] = cmpb_buf;
      TMW_ADDR_CAPT:     rd_data[15:0] = capt_q;
      TMW_ADDR_CNT:      rd_data[15:0] = cnt_q;
      TMW_ADDR_IRQ_STAT: rd_data[3:0] = stat_q;
      TMW_ADDR_IRQ_MASK: rd_data[3:0] = mask_q;
      default:           rd_hit = 1'b0;
    endcase
  end

  // Read channel: data registered at address accept, one read at a time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= TMW_RESP_OKAY;
    end else begin
      if (ar_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_data;
        s_axi_rresp  <= rd_hit ? TMW_RESP_OKAY : TMW_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      s_axi_arready <= !(ar_take || (s_axi_rvalid && !s_axi_rready));
    end
  end

  // Control registers; bits 3:2 of the first stay zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_a_q  <= TMW_RST_BYTE;
      wm_high_q <= 2'b00;
    end else begin
      if (wr_ctrl_a) begin
        ctrl_a_q      <= wdata_q[7:0];
        ctrl_a_q.rsvd <= 2'b00;
      end
      if (wr_ctrl_b) begin
        wm_high_q <= wdata_q[TMW_WMH_MSB:TMW_WMH_LSB]; // [R17]
      end
    end
  end

  // Mode decode and TOP selection
  assign waveform_mode = {wm_high_q, ctrl_a_q.waveform_mode_low}; // [R12]
  assign mode = tmw_decode(waveform_mode); // [R12]
  assign dual = (mode.kind == TMW_K_PC) || (mode.kind == TMW_K_PFC);
  assign immediate = (mode.kind == TMW_K_NORMAL) || (mode.kind == TMW_K_CTC) || (mode.kind == TMW_K_RESV); // [R15]
  // Fixed-TOP modes mask unused compare bits on write, so a match stays reachable
  assign cmp_mask = (mode.src == TMW_SRC_FIXED) ? mode.fixed_top : TMW_TOP_MAX;

  always_comb begin
    unique case (mode.src)
      TMW_SRC_CMPA: top_v = cmpa_act; // [R13] [R14] [R15] [R16]
      TMW_SRC_CAPT: top_v = capt_q;
      default:      top_v = mode.fixed_top;
    endcase
  end

  assign at_top = (cnt_q == top_v);
  assign at_bot = (cnt_q == TMW_RST_WORD);

  // Counter: single slope wraps at TOP, dual slope turns at TOP and BOTTOM
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= TMW_RST_WORD;
    end else if (wr_cnt) begin
      cnt_q <= merge16(cnt_q, wdata_q, wstrb_q);
    end else if (timer_tick) begin // [R1]
      if (!dual) begin
        cnt_q <= at_top ? TMW_RST_WORD : cnt_q + 16'h0001;
      end else if (dir_up_q) begin
        cnt_q <= at_top ? cnt_q - 16'h0001 : cnt_q + 16'h0001;
      end else begin
        cnt_q <= at_bot ? cnt_q + 16'h0001 : cnt_q - 16'h0001;
      end
    end
  end

  // Count direction, always up outside the dual-slope modes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dir_up_q <= 1'b1;
    end else if (!dual) begin
      dir_up_q <= 1'b1;
    end else if (timer_tick) begin
      if (dir_up_q && at_top) dir_up_q <= 1'b0;
      else if (!dir_up_q && at_bot) dir_up_q <= 1'b1;
    end
  end

  // Reload point and overflow point per family
  always_comb begin
    reload  = 1'b0;
    ovf_set = 1'b0;
    if (timer_tick) begin // [R19]
      unique case (mode.kind)
        TMW_K_PC: begin
          reload  = at_top && dir_up_q; // [R13]
          ovf_set = at_bot && !dir_up_q; // [R13]
        end
        TMW_K_PFC: begin
          reload  = at_bot && !dir_up_q; // [R2] [R16]
          ovf_set = at_bot && !dir_up_q; // [R16]
        end
        TMW_K_FAST: begin
          reload  = at_top; // [R14]
          ovf_set = at_top; // [R14]
        end
        default: ovf_set = (cnt_q == TMW_TOP_MAX); // [R15]
      endcase
    end
  end

  tmw_cmp_buf u_cmp_a (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .wr_en     (wr_cmpa),
    .wr_data   (merge16(cmpa_buf, wdata_q, wstrb_q) & cmp_mask),
    .immediate (immediate),
    .reload    (reload),
    .buf_q     (cmpa_buf),
    .act_q     (cmpa_act)
  );

  tmw_cmp_buf u_cmp_b (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .wr_en     (wr_cmpb),
    .wr_data   (merge16(cmpb_buf, wdata_q, wstrb_q) & cmp_mask),
    .immediate (immediate),
    .reload    (reload),
    .buf_q     (cmpb_buf),
    .act_q     (cmpb_act)
  );

  // Capture only while TOP does not come from the capture register
  assign capt_set = capture_event && (mode.src != TMW_SRC_CAPT); // [R18]

  // Hardware capture wins over a software write in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      capt_q <= TMW_RST_WORD;
    end else if (capt_set) begin
      capt_q <= cnt_q;
    end else if (wr_capt) begin
      capt_q <= merge16(capt_q, wdata_q, wstrb_q);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      capture_enabled <= 1'b1;
    end else begin
      capture_enabled <= (mode.src != TMW_SRC_CAPT); // [R18]
    end
  end

  // Matches and channel events
  assign match_a  = timer_tick && (cnt_q == cmpa_act); // [R19]
  assign match_b  = timer_tick && (cnt_q == cmpb_act); // [R19]
  assign toggle_a = (waveform_mode == TMW_WM_FAST_CAPT) || (waveform_mode == TMW_WM_FAST_CMPA) ||
                    (waveform_mode == TMW_WM_PFC_CMPA) || (waveform_mode == TMW_WM_PC_CMPA); // [R7] [R10]
  assign evt_a = '{timer_tick, match_a, timer_tick && mode.kind == TMW_K_FAST && at_top, dir_up_q,
                   cmpa_act == top_v};
  assign evt_b = '{timer_tick, match_b, timer_tick && mode.kind == TMW_K_FAST && at_top, dir_up_q,
                   cmpb_act == top_v};

  tmw_wave_chan u_chan_a (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .evt       (evt_a),
    .kind      (mode.kind),
    .out_mode  (ctrl_a_q.chan_a_output_mode),
    .toggle_ok (toggle_a),
    .wave_q    (wave_out_a),
    .conn_q    (wave_a_override) // [R3]
  );

  // Channel B never toggles in the PWM families
  tmw_wave_chan u_chan_b (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .evt       (evt_b),
    .kind      (mode.kind),
    .out_mode  (ctrl_a_q.chan_b_output_mode),
    .toggle_ok (1'b0),
    .wave_q    (wave_out_b),
    .conn_q    (wave_b_override) // [R4]
  );

  // Sticky status: a new event beats a write-one clear in the same cycle
  always_comb begin
    stat_d = stat_q;
    if (wr_stat) stat_d = stat_d & ~wdata_q[3:0];
    stat_d[TMW_IRQ_OVF]     = stat_d[TMW_IRQ_OVF] | ovf_set;
    stat_d[TMW_IRQ_MATCH_A] = stat_d[TMW_IRQ_MATCH_A] | match_a;
    stat_d[TMW_IRQ_MATCH_B] = stat_d[TMW_IRQ_MATCH_B] | match_b;
    stat_d[TMW_IRQ_CAPT]    = stat_d[TMW_IRQ_CAPT] | capt_set;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_q <= TMW_RST_IRQ;
      mask_q <= TMW_RST_IRQ;
    end else begin
      stat_q <= stat_d;
      if (wr_mask) mask_q <= wdata_q[3:0];
    end
  end

  // Interrupt registered from the current status, one cycle behind it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(stat_q & mask_q);
    end
  end

endmodule // tmw_timer_top
`default_nettype wire

// file: bench/tmw_timer_checker.sv
`timescale 1ns/100ps
`default_nettype none
module tmw_timer_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic timer_tick,
  input wire logic capture_event,
  input wire logic capture_enabled,
  input wire logic wave_out_a,
  input wire logic wave_out_b,
  input wire logic wave_a_override,
  input wire logic wave_b_override,
  input wire logic irq
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Waveforms may only move on the edge that samples a tick
  property p_wave_a; $changed(wave_out_a) |-> $past(timer_tick); endproperty
  a_wave_a: assert property (p_wave_a) else $error("wave a moved off tick");
  property p_wave_b; $changed(wave_out_b) |-> $past(timer_tick); endproperty
  a_wave_b: assert property (p_wave_b) else $error("wave b moved off tick");
  // Pin ownership and capture gating follow a landed write, one cycle slack
  property p_ovr_a; $changed(wave_a_override) |-> s_axi_bvalid || $past(s_axi_bvalid); endproperty
  a_ovr_a: assert property (p_ovr_a) else $error("override a moved without write");
  property p_ovr_b; $changed(wave_b_override) |-> s_axi_bvalid || $past(s_axi_bvalid); endproperty
  a_ovr_b: assert property (p_ovr_b) else $error("override b moved without write");
  property p_capt; $changed(capture_enabled) |-> s_axi_bvalid || $past(s_axi_bvalid); endproperty
  a_capt: assert property (p_capt) else $error("capture gate moved without write");
  // Register bus answers within its fixed latency
  property p_wr; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid; endproperty
  a_wr: assert property (p_wr) else $error("write response late");
  property p_rd; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rd: assert property (p_rd) else $error("read data late");
  // Interrupt lags its cause: an event two cycles back or a mask write
  property p_irq;
    $rose(irq) |-> $past(timer_tick, 2) || $past(capture_event, 2) || $past(s_axi_bvalid);
  endproperty
  a_irq: assert property (p_irq) else $error("irq rose without cause");
endmodule // tmw_timer_checker
bind tmw_timer_top tmw_timer_checker u_tmw_timer_checker (.*);
`default_nettype wire

// file: bench/tmw_pin_model.sv
`timescale 1ns/100ps
`default_nettype none
module tmw_pin_model (
  input  wire logic wave,
  input  wire logic ovr,
  input  wire logic dir_out,
  input  wire logic port_val,
  output wire logic pin
);
  // Driver off leaves the pin at its pull-up level
  assign pin = !dir_out ? 1'b1 : (ovr ? wave : port_val);
endmodule // tmw_pin_model
`default_nettype wire

// file: bench/test_timer16_waveform_mode_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
module test_timer16_waveform_mode_ctrl;
  import tmw_pkg::*;
  logic aclk = 0, aresetn = 0, timer_tick = 0, capture_event = 0, dir_out = 0, pin_a;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 1, s_axi_arvalid = 0, s_axi_rready = 1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic capture_enabled, wave_out_a, wave_out_b, wave_a_override, wave_b_override, irq;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int n_errors = 0, num_checks = 0, cyc = 0;
  always #4 aclk = ~aclk;
  tmw_timer_top u_tmw_timer_top (.*);
  tmw_pin_model u_tmw_pin_model (.wave(wave_out_a), .ovr(wave_a_override), .dir_out(dir_out),
                                 .port_val(1'b0), .pin(pin_a));
  // Hang guard, well above the roughly eight hundred cycles the run needs
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      complete_run();
    end
  end
  task complete_run;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task chk(input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %0t expected %h got %h", $time, e, g);
    end
  endtask
  // Both write channels offered together, each released once taken
  task wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_awvalid && !s_axi_awready || s_axi_wvalid && !s_axi_wready);
    while (!s_axi_bvalid) @(posedge aclk);
    chk(TMW_RESP_OKAY, s_axi_bresp);
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    while (!s_axi_rvalid) @(posedge aclk);
    chk(e, s_axi_rdata);
    chk(r, s_axi_rresp);
  endtask
  // Tick held for n edges gives n counts; one idle edge lets outputs settle
  task tk(input int n);
    timer_tick <= 1'b1;
    repeat (n) @(posedge aclk);
    timer_tick <= 1'b0;
    @(posedge aclk);
  endtask
  task t_regs;
    rdc(TMW_ADDR_CTRL_A, 32'h0, TMW_RESP_OKAY);
    rdc(8'ha0, 32'h0, TMW_RESP_SLVERR);
    wr(TMW_ADDR_CTRL_A, 32'hff);
    rdc(TMW_ADDR_CTRL_A, 32'hf3, TMW_RESP_OKAY);
    chk(2'b11, {wave_a_override, wave_b_override});
    capture_event <= 1'b1;
    @(posedge aclk);
    capture_event <= 1'b0;
    rdc(TMW_ADDR_IRQ_STAT, 32'h8, TMW_RESP_OKAY);
    $display("t_regs done");
  endtask
  // Every mode: capture gating, upper bits readback, pin ownership
  task t_modes;
    for (int m = 0; m < 16; m++) begin
      wr(TMW_ADDR_CTRL_A, (m[0] ? 32'h80 : 32'h10) | m[1:0]);
      wr(TMW_ADDR_CTRL_B, {m[3:2], 3'h0});
      rdc(TMW_ADDR_CTRL_B, {m[3:2], 3'h0}, TMW_RESP_OKAY);
      chk(!(m inside {8, 10, 12, 14}), capture_enabled);
      chk(m[0] ? 2'b10 : 2'b01, {wave_a_override, wave_b_override});
    end
    $display("t_modes done");
  endtask
  // Toggle, clear, set in normal mode, then raise, mask and clear the irq
  task t_normal;
    wr(TMW_ADDR_CTRL_B, 32'h0);
    wr(TMW_ADDR_IRQ_MASK, 32'h2);
    for (int k = 1; k < 4; k++) begin
      wr(TMW_ADDR_CTRL_A, k * 32'h50);
      wr(TMW_ADDR_CMP_A, 32'h5);
      wr(TMW_ADDR_CMP_B, 32'h5);
      wr(TMW_ADDR_CNT, 32'h0);
      tk(6);
      chk(k != 2, wave_out_a);
      chk(k != 2, wave_out_b);
    end
    @(posedge aclk);
    chk(1'b1, irq);
    wr(TMW_ADDR_IRQ_MASK, 32'h0);
    @(posedge aclk);
    chk(1'b0, irq);
    wr(TMW_ADDR_IRQ_MASK, 32'h2);
    wr(TMW_ADDR_IRQ_STAT, 32'h2);
    @(posedge aclk);
    chk(1'b0, irq);
    $display("t_normal done");
  endtask
  // Fast 8-bit inverting: clear at wrap, new compare loaded there
  task t_fast;
    wr(TMW_ADDR_CTRL_B, 32'h8);
    wr(TMW_ADDR_CTRL_A, 32'hc1);
    wr(TMW_ADDR_CMP_A, 32'h10);
    wr(TMW_ADDR_CNT, 32'hfe);
    wr(TMW_ADDR_IRQ_STAT, 32'hf);
    tk(2);
    chk(1'b0, wave_out_a);
    rdc(TMW_ADDR_IRQ_STAT, 32'h1, TMW_RESP_OKAY);
    dir_out <= 1'b1;
    @(posedge aclk);
    chk(1'b0, pin_a);
    dir_out <= 1'b0;
    @(posedge aclk);
    chk(1'b1, pin_a);
    tk(16);
    chk(1'b0, wave_out_a);
    tk(1);
    chk(1'b1, wave_out_a);
    $display("t_fast done");
  endtask
  // Phase correct 8-bit: clear on the up match, set on the down match
  task t_pc;
    wr(TMW_ADDR_CTRL_A, 32'h0);
    wr(TMW_ADDR_CTRL_B, 32'h0);
    wr(TMW_ADDR_CMP_A, 32'h2);
    wr(TMW_ADDR_CTRL_A, 32'h81);
    wr(TMW_ADDR_CNT, 32'h0);
    tk(3);
    chk(1'b0, wave_out_a);
    tk(505);
    chk(1'b0, wave_out_a);
    tk(1);
    chk(1'b1, wave_out_a);
    $display("t_pc done");
  endtask
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_regs;
    t_modes;
    t_normal;
    t_fast;
    t_pc;
    complete_run;
  end
endmodule // test_timer16_waveform_mode_ctrl
`default_nettype wire
